// >>> src/t16_dev.sv
// Sixteen-bit timer with byte-wide register access through one holding byte.
// Notes on behaviour
// - Wide registers reached as two byte accesses.
// - One holding byte shared by all.
// - Low write loads holding and low together.
// - Low read copies upper byte to holding.
// - Compare reads return upper byte directly.
// - Host writes high first, reads low first.
// - Host resamples the request and never blocks it.
// - Control bytes read and written freely.
// - Clock select picks tick source or stops.
// - Buffered compares checked against counter on each tick.
// - Compare match sets its channel flag.
// - Capture edge stores counter unless capture is top, optional filter.
// - Bottom at zero, max at all ones.
// - Top fixed, compare A or capture.
// - Compare A as PWM top: no output.
// - Host uses capture for fixed top.
// - Flags visible, each gated by mask.
// - Host counter write beats counting.
// - Capture writable only when it is top.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
module t16_dev (
   input  wire logic       clk_i,   // System clock.
   input  wire logic       rst_i,   // Synchronous reset.
   input  wire logic       ext_count_pin_i, // External count pin.
   input  wire logic       capture_input_pin_i, // Capture pin.
   input  wire logic       cmp_in_i, // Comparator output, capture source.
   output logic [2:0]      compare_output_pins_o, // Waveform outputs.
   output logic            bottom_o, // Counter at zero.
   output logic            max_o,    // Counter at all ones.
   t16_if.dev              lnk       // Register link.
);
   localparam int NF = t16_pkg::NFLAG;
   logic [7:0]  timer_control_regs [3];
   logic [7:0]  hold_reg;
   logic [15:0] count_value;
   logic [15:0] capture_value;
   logic [15:0] cmp_buf [3];
   logic [15:0] cmp_act [3];
   logic [15:0] top;
   logic [3:0]  mode;
   logic [2:0]  csel;
   logic        pwm;
   logic        cap_top;
   logic        tick;
   logic        wrap;
   logic [2:0]  match;
   logic [NF-1:0] timer_flag_reg;
   logic [NF-1:0] timer_mask_reg;
   logic [NF-1:0] fset;
   logic [NF-1:0] fclr;
   logic [t16_pkg::PREW-1:0] pre_reg;
   logic [2:0]  ext_s;
   logic [1:0]  cap_s;
   logic [1:0]  cmpi_s;
   logic [t16_pkg::NFILT-1:0] filt_reg;
   logic        cap_lvl_reg;
   logic        cap_prev_reg;
   logic        cap_raw;
   logic        cap_now;
   logic        cap_evt;

   assign mode = {timer_control_regs[1][4:3], timer_control_regs[0][1:0]};
   assign csel = timer_control_regs[1][2:0];
   assign pwm  = (mode[2:0] != 3'h0 && mode[2:0] != t16_pkg::M_CTC_A[2:0])
                 || mode == t16_pkg::M_PWM_C || mode == t16_pkg::M_PWM_A;
   assign cap_top = mode == t16_pkg::M_CTC_C || mode == t16_pkg::M_PWM_C;
   assign wrap = tick && count_value == top;

   // ----------------------------------------------------------------
   // Top selection
   // ----------------------------------------------------------------
   always_comb begin
      case (mode)
         4'h1, 4'h5:       top = t16_pkg::TOP_8;
         4'h2, 4'h6:       top = t16_pkg::TOP_9;
         4'h3, 4'h7:       top = t16_pkg::TOP_10;
         t16_pkg::M_CTC_A,
         t16_pkg::M_PWM_A: top = cmp_act[0];
         t16_pkg::M_CTC_C,
         t16_pkg::M_PWM_C: top = capture_value;
         default:          top = t16_pkg::MAXV;
      endcase
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and timer tick
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_s  <= 3'h0;
         cap_s  <= 2'h0;
         cmpi_s <= 2'h0;
      end else begin
         ext_s  <= {ext_s[1:0], ext_count_pin_i};
         cap_s  <= {cap_s[0], capture_input_pin_i};
         cmpi_s <= {cmpi_s[0], cmp_in_i};
      end
   end

   // The prescaler runs free, so the first prescaled tick after a start
   // may come anywhere within one divided period.
   always_ff @(posedge clk_i) begin
      if (rst_i) pre_reg <= '0;
      else pre_reg <= pre_reg + 1'b1;
   end

   always_comb begin
      case (csel)
         t16_pkg::CS_SYS:  tick = 1'b1;
         t16_pkg::CS_D8:   tick = &pre_reg[2:0];
         t16_pkg::CS_D64:  tick = &pre_reg[5:0];
         t16_pkg::CS_D256: tick = &pre_reg[7:0];
         t16_pkg::CS_D1K:  tick = &pre_reg;
         t16_pkg::CS_FALL: tick = ext_s[2] && !ext_s[1];
         t16_pkg::CS_RISE: tick = !ext_s[2] && ext_s[1];
         default:          tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) count_value <= t16_pkg::BOTV;
      else if (lnk.wr && lnk.addr == t16_pkg::A_CNTL) count_value <= {hold_reg, lnk.wdata};
      else if (wrap) count_value <= t16_pkg::BOTV;
      else if (tick) count_value <= count_value + 16'h0001;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bottom_o <= 1'b1;
         max_o    <= 1'b0;
      end else begin
         bottom_o <= count_value == t16_pkg::BOTV;
         max_o    <= count_value == t16_pkg::MAXV;
      end
   end

   // ----------------------------------------------------------------
   // Holding byte and control bytes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) hold_reg <= 8'h00;
      else if (lnk.wr && (lnk.addr == t16_pkg::A_CNTH || lnk.addr == t16_pkg::A_CAPH
               || lnk.addr == t16_pkg::A_CMPL + 5'h01 || lnk.addr == t16_pkg::A_CMPL + 5'h03
               || lnk.addr == t16_pkg::A_CMPL + 5'h05)) hold_reg <= lnk.wdata;
      else if (lnk.rd && lnk.addr == t16_pkg::A_CNTL) hold_reg <= count_value[15:8];
      else if (lnk.rd && lnk.addr == t16_pkg::A_CAPL) hold_reg <= capture_value[15:8];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_regs <= '{default: 8'h00};
      end else if (lnk.wr && lnk.addr <= t16_pkg::A_CTLC) begin
         timer_control_regs[lnk.addr[1:0]] <= lnk.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Compare channels
   // ----------------------------------------------------------------
   generate
      for (genvar c = 0; c < 3; c++) begin : g_cmp
         localparam logic [4:0] LO = t16_pkg::A_CMPL + 5'(c * 2);
         assign match[c] = tick && count_value == cmp_act[c];
         always_ff @(posedge clk_i) begin
            if (rst_i) cmp_buf[c] <= 16'h0000;
            else if (lnk.wr && lnk.addr == LO) cmp_buf[c] <= {hold_reg, lnk.wdata};
         end
         // In PWM modes the new value only takes effect at the period end.
         always_ff @(posedge clk_i) begin
            if (rst_i) cmp_act[c] <= 16'h0000;
            else if (!pwm || wrap) cmp_act[c] <= cmp_buf[c];
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) compare_output_pins_o[c] <= 1'b0;
            else if (c == 0 && mode == t16_pkg::M_PWM_A) compare_output_pins_o[c] <= 1'b0;
            else if (pwm && wrap) compare_output_pins_o[c] <= 1'b1;
            else if (match[c]) compare_output_pins_o[c] <= pwm ? 1'b0 : !compare_output_pins_o[c];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Capture unit
   // ----------------------------------------------------------------
   assign cap_raw = timer_control_regs[2][0] ? cmpi_s[1] : cap_s[1];
   assign cap_now = timer_control_regs[1][7] ? cap_lvl_reg : cap_raw;
   assign cap_evt = !cap_top && (cap_now != cap_prev_reg)
                    && (cap_now == timer_control_regs[1][6]);

   // The filter accepts a new level only after it is seen on every sample.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filt_reg     <= '0;
         cap_lvl_reg  <= 1'b0;
         cap_prev_reg <= 1'b0;
      end else begin
         filt_reg     <= {filt_reg[t16_pkg::NFILT-2:0], cap_raw};
         if (&filt_reg) cap_lvl_reg <= 1'b1;
         else if (~|filt_reg) cap_lvl_reg <= 1'b0;
         cap_prev_reg <= cap_now;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) capture_value <= 16'h0000;
      else if (cap_top && lnk.wr && lnk.addr == t16_pkg::A_CAPL)
         capture_value <= {hold_reg, lnk.wdata};
      else if (cap_evt) capture_value <= count_value;
   end

   // ----------------------------------------------------------------
   // Flags, mask and request
   // ----------------------------------------------------------------
   assign fset = {cap_evt, match & 3'(~0), wrap};
   assign fclr = (lnk.wr && lnk.addr == t16_pkg::A_FLAG) ? lnk.wdata[NF-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) timer_flag_reg <= '0;
      else timer_flag_reg <= (timer_flag_reg & ~fclr) | fset;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) timer_mask_reg <= '0;
      else if (lnk.wr && lnk.addr == t16_pkg::A_MASK) timer_mask_reg <= lnk.wdata[NF-1:0];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) lnk.irq <= 1'b0;
      else lnk.irq <= |(timer_flag_reg & timer_mask_reg);
   end

   // ----------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) lnk.rdata <= 8'h00;
      else if (lnk.rd) begin
         case (lnk.addr)
            t16_pkg::A_CTLA, t16_pkg::A_CTLB,
            t16_pkg::A_CTLC: lnk.rdata <= timer_control_regs[lnk.addr[1:0]];
            t16_pkg::A_CNTL: lnk.rdata <= count_value[7:0];
            t16_pkg::A_CAPL: lnk.rdata <= capture_value[7:0];
            t16_pkg::A_CNTH,
            t16_pkg::A_CAPH: lnk.rdata <= hold_reg;
            5'h05:           lnk.rdata <= cmp_buf[0][7:0];
            5'h06:           lnk.rdata <= cmp_buf[0][15:8];
            5'h07:           lnk.rdata <= cmp_buf[1][7:0];
            5'h08:           lnk.rdata <= cmp_buf[1][15:8];
            5'h09:           lnk.rdata <= cmp_buf[2][7:0];
            5'h0A:           lnk.rdata <= cmp_buf[2][15:8];
            t16_pkg::A_FLAG: lnk.rdata <= {3'h0, timer_flag_reg};
            t16_pkg::A_MASK: lnk.rdata <= {3'h0, timer_mask_reg};
            default:         lnk.rdata <= 8'h00;
         endcase
      end
   end
endmodule // t16_dev

// >>> src/t16_pkg.sv
// Shared constants for the 16-bit timer and its byte-bus controller.
package t16_pkg;
   // ----------------------------------------------------------------
   // Byte map of the timer on the link
   // ----------------------------------------------------------------
   localparam logic [4:0] A_CTLA  = 5'h00;
   localparam logic [4:0] A_CTLB  = 5'h01;
   localparam logic [4:0] A_CTLC  = 5'h02;
   localparam logic [4:0] A_CNTL  = 5'h03;
   localparam logic [4:0] A_CNTH  = 5'h04;
   localparam logic [4:0] A_CMPL  = 5'h05; // A low; B and C follow in pairs
   localparam logic [4:0] A_CAPL  = 5'h0B;
   localparam logic [4:0] A_CAPH  = 5'h0C;
   localparam logic [4:0] A_FLAG  = 5'h0D;
   localparam logic [4:0] A_MASK  = 5'h0E;
   localparam logic [4:0] A_STEP  = 5'h02;
   // ----------------------------------------------------------------
   // Clock select, modes, fixed tops
   // ----------------------------------------------------------------
   localparam logic [2:0] CS_OFF  = 3'h0;
   localparam logic [2:0] CS_SYS  = 3'h1;
   localparam logic [2:0] CS_D8   = 3'h2;
   localparam logic [2:0] CS_D64  = 3'h3;
   localparam logic [2:0] CS_D256 = 3'h4;
   localparam logic [2:0] CS_D1K  = 3'h5;
   localparam logic [2:0] CS_FALL = 3'h6;
   localparam logic [2:0] CS_RISE = 3'h7;
   localparam logic [3:0] M_CTC_A = 4'h4;
   localparam logic [3:0] M_CTC_C = 4'hC;
   localparam logic [3:0] M_PWM_C = 4'hE;
   localparam logic [3:0] M_PWM_A = 4'hF;
   localparam logic [15:0] TOP_8  = 16'h00FF;
   localparam logic [15:0] TOP_9  = 16'h01FF;
   localparam logic [15:0] TOP_10 = 16'h03FF;
   localparam logic [15:0] MAXV   = 16'hFFFF;
   localparam logic [15:0] BOTV   = 16'h0000;
   // ----------------------------------------------------------------
   // Flag bits, filter, prescaler
   // ----------------------------------------------------------------
   localparam int F_OVF = 0;
   localparam int F_CMP = 1; // channels A..C at 1..3
   localparam int F_CAP = 4;
   localparam int NFLAG = 5;
   localparam int NFILT = 4;
   localparam int PREW  = 10;
   // ----------------------------------------------------------------
   // Controller registers (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] W_DATA = 4'h0;
   localparam logic [3:0] W_CMD  = 4'h4;
   localparam logic [3:0] W_STAT = 4'h8;
   localparam logic [3:0] W_RES  = 4'hC;
   localparam int C_WR   = 8;
   localparam int C_WIDE = 9;
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_ONE = 2'b01, H_TWO = 2'b11,
                             H_LAST = 2'b10} t16_hst_t;
endpackage

// >>> src/t16_if.sv
// Byte-wide register link between the timer and its controller.
interface t16_if (
   input wire logic clk_i
);
   logic [4:0] addr;  // Byte location.
   logic [7:0] wdata; // Write byte.
   logic       wr;    // One-cycle write strobe.
   logic       rd;    // One-cycle read strobe.
   logic [7:0] rdata; // Read byte, valid the cycle after rd.
   logic       irq;   // Masked request level.
   modport dev (input addr, wdata, wr, rd, output rdata, irq);
   modport host (output addr, wdata, wr, rd, input rdata, irq);
endinterface

// >>> src/t16_host.sv
// Wishbone controller that performs ordered byte accesses on the timer link.
module t16_host (
   input  wire logic        clk_i,  // System clock.
   input  wire logic        rst_i,  // Synchronous reset.
   input  wire logic        cyc_i,  // Wishbone cycle.
   input  wire logic        stb_i,  // Wishbone strobe.
   input  wire logic        we_i,   // Write enable.
   input  wire logic [3:0]  adr_i,  // Byte address.
   input  wire logic [3:0]  sel_i,  // Byte lanes.
   input  wire logic [31:0] dat_i,  // Write data.
   output logic      [31:0] dat_o,  // Read data.
   output logic             ack_o,  // Acknowledge.
   output logic             irq_o,  // Timer request, resampled.
   t16_if.host              lnk     // Timer link.
);
   logic [15:0]        data_reg;
   logic [15:0]        res_reg;
   logic [4:0]         base_reg;
   logic               wr_reg;
   logic               wide_reg;
   t16_pkg::t16_hst_t  st_reg;
   logic               rv_reg;
   logic               rhi_reg;
   logic               req;
   logic               go;

   assign req = cyc_i && stb_i && !ack_o;
   assign go  = req && we_i && adr_i == t16_pkg::W_CMD && sel_i[0] && st_reg == t16_pkg::H_IDLE;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         dat_o <= 32'h0000_0000;
         if (req && !we_i) begin
            case (adr_i)
               t16_pkg::W_DATA: dat_o <= {16'h0000, data_reg};
               t16_pkg::W_STAT: dat_o <= {31'h0000_0000, st_reg != t16_pkg::H_IDLE || rv_reg};
               t16_pkg::W_RES:  dat_o <= {16'h0000, res_reg};
               default:         dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_reg <= 16'h0000;
      end else if (req && we_i && adr_i == t16_pkg::W_DATA) begin
         if (sel_i[0]) data_reg[7:0] <= dat_i[7:0];
         if (sel_i[1]) data_reg[15:8] <= dat_i[15:8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_reg <= 5'h00;
         wr_reg   <= 1'b0;
         wide_reg <= 1'b0;
      end else if (go) begin
         base_reg <= dat_i[4:0];
         wr_reg   <= dat_i[t16_pkg::C_WR];
         wide_reg <= dat_i[t16_pkg::C_WIDE] && sel_i[1];
      end
   end

   // ----------------------------------------------------------------
   // Link sequencer
   // ----------------------------------------------------------------
   // A wide write puts the upper byte first, a wide read takes the lower
   // byte first, so the timer's shared holding byte is used correctly.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg    <= t16_pkg::H_IDLE;
         lnk.addr  <= 5'h00;
         lnk.wdata <= 8'h00;
         lnk.wr    <= 1'b0;
         lnk.rd    <= 1'b0;
      end else begin
         lnk.wr <= 1'b0;
         lnk.rd <= 1'b0;
         case (st_reg)
            t16_pkg::H_IDLE: if (go) st_reg <= t16_pkg::H_ONE;
            t16_pkg::H_ONE: begin
               st_reg <= t16_pkg::H_TWO;
               lnk.wr <= wr_reg;
               lnk.rd <= !wr_reg;
               if (wr_reg && wide_reg) begin
                  lnk.addr  <= base_reg + 5'h01;
                  lnk.wdata <= data_reg[15:8];
               end else begin
                  lnk.addr  <= base_reg;
                  lnk.wdata <= data_reg[7:0];
               end
            end
            t16_pkg::H_TWO: begin
               st_reg <= (wide_reg) ? t16_pkg::H_LAST : t16_pkg::H_IDLE;
               if (wide_reg) begin
                  lnk.wr    <= wr_reg;
                  lnk.rd    <= !wr_reg;
                  lnk.addr  <= wr_reg ? base_reg : base_reg + 5'h01;
                  lnk.wdata <= data_reg[7:0];
               end
            end
            t16_pkg::H_LAST: st_reg <= t16_pkg::H_IDLE;
            default: st_reg <= t16_pkg::H_IDLE;
         endcase
      end
   end

   // A read byte stands on the link from the cycle after its strobe until the next read.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rv_reg  <= 1'b0;
         rhi_reg <= 1'b0;
         res_reg <= 16'h0000;
      end else begin
         rv_reg  <= lnk.rd;
         rhi_reg <= lnk.rd && st_reg == t16_pkg::H_LAST;
         if (rv_reg && rhi_reg) res_reg[15:8] <= lnk.rdata;
         else if (rv_reg) res_reg <= {8'h00, lnk.rdata};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) irq_o <= 1'b0;
      else irq_o <= lnk.irq;
   end
endmodule // t16_host

// >>> tb/t16_assertions.sv
// Checker for the byte link between the timer and its controller.
module t16_assertions (
   input wire logic       clk_i, // System clock.
   input wire logic       rst_i, // Synchronous reset.
   input wire logic [4:0] addr,  // Byte location.
   input wire logic [7:0] wdata, // Write byte.
   input wire logic       wr,    // Write strobe.
   input wire logic       rd,    // Read strobe.
   input wire logic [7:0] rdata, // Read byte.
   input wire logic       irq    // Request level.
);
   logic [7:0]  ctl_reg [3];
   logic [15:0] cmp_reg [3];
   logic [7:0]  hold_reg;
   logic [4:0]  ra_reg;
   logic        rv_reg;
   logic [4:0]  ra_off;
   logic [4:0]  wa_off;
   logic [7:0]  cmp_byte;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Shadows
   // ----------------------------------------------------------------
   // Compare shadows assume high-then-low writes with no low read between.
   assign wa_off = addr - 5'h05;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_reg  <= '{default: 8'h00};
         cmp_reg  <= '{default: 16'h0000};
         hold_reg <= 8'h00;
      end else if (wr) begin
         if (addr <= t16_pkg::A_CTLC) ctl_reg[addr[1:0]] <= wdata;
         if (addr inside {5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C}) hold_reg <= wdata;
         if (addr inside {5'h05, 5'h07, 5'h09}) cmp_reg[wa_off[2:1]] <= {hold_reg, wdata};
      end
   end
   always_ff @(posedge clk_i) begin
      rv_reg <= rd && !rst_i;
      if (rd) ra_reg <= addr;
   end
   always_comb begin
      ra_off   = ra_reg - 5'h05;
      cmp_byte = ra_reg[0] ? cmp_reg[ra_off[2:1]][7:0] : cmp_reg[ra_off[2:1]][15:8];
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_wr_burst: assert property (wr ##1 wr |=> !wr)
      else $error("write strobe longer than two cycles");
   a_rd_burst: assert property (rd ##1 rd |=> !rd)
      else $error("read strobe longer than two cycles");
   a_strobe_excl: assert property (!(wr && rd))
      else $error("read and write strobes together");
   a_wide_wr_order: assert property (wr && $past(wr) |-> addr == $past(addr) - 5'h01)
      else $error("wide write not high byte first");
   a_wide_rd_order: assert property (rd && $past(rd) |-> addr == $past(addr) + 5'h01)
      else $error("wide read not low byte first");
   a_rdata_hold: assert property (!$past(rd) |-> $stable(rdata))
      else $error("read byte changed without a read");
   a_ctl_readback: assert property (rv_reg && ra_reg <= t16_pkg::A_CTLC |-> rdata == ctl_reg[ra_reg[1:0]])
      else $error("control byte read differs from write");
   a_cmp_readback: assert property (rv_reg && ra_reg inside {[5'h05:5'h0A]} |-> rdata == cmp_byte)
      else $error("compare byte read differs from write");
endmodule // t16_assertions

// >>> tb/tb.sv
// Self-checking bench for the timer and its Wishbone controller.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat_w = 32'h00000000;
   logic [31:0] dat_r;
   logic        ack;
   logic        irq;
   logic        ext_pin = 1'b0;
   logic        cap_pin = 1'b0;
   logic        cmp_pin = 1'b0;
   logic        bottom;
   logic        maxv;
   logic [2:0]  wave;
   int          fails = 0;
   int          n_tests = 0;
   int          cycles = 0;
   always #12.5 clk_i = ~clk_i;
   t16_if lnk (.clk_i(clk_i));
   t16_host t16_host_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .irq_o(irq),
      .lnk(lnk));
   t16_dev t16_dev_i (.clk_i(clk_i), .rst_i(rst_i), .ext_count_pin_i(ext_pin),
      .capture_input_pin_i(cap_pin), .cmp_in_i(cmp_pin), .compare_output_pins_o(wave),
      .bottom_o(bottom), .max_o(maxv), .lnk(lnk));
   t16_assertions t16_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .addr(lnk.addr),
      .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata), .irq(lnk.irq));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk_i);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      sel   <= 4'h3;
      dat_w <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // One ordered link access; the controller does the byte sequencing.
   task automatic op(input logic w, input logic wide, input logic [4:0] a,
                     input logic [15:0] d, output logic [15:0] q);
      logic [31:0] r;
      if (w) wb(1'b1, t16_pkg::W_DATA, {16'h0000, d}, r);
      wb(1'b1, t16_pkg::W_CMD, {22'h000000, wide, w, 3'h0, a}, r);
      do wb(1'b0, t16_pkg::W_STAT, 32'h00000000, r); while (r[0] !== 1'b0);
      wb(1'b0, t16_pkg::W_RES, 32'h00000000, r);
      q = r[15:0];
   endtask
   task automatic wr(input logic wide, input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      op(1'b1, wide, a, d, q);
   endtask
   task automatic rc(input logic wide, input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] q;
      op(1'b0, wide, a, 16'h0000, q);
      chk(wide ? q : {8'h00, q[7:0]}, exp);
   endtask
   task automatic fc(input logic [15:0] mask, input logic [15:0] exp);
      logic [15:0] q;
      op(1'b0, 1'b0, t16_pkg::A_FLAG, 16'h0000, q);
      chk({8'h00, q[7:0]} & mask, exp);
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [15:0] q;
      logic [7:0]  ctl_v [3] = '{8'hA0, 8'h80, 8'h00};
      logic [2:0]  w0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({14'h0000, bottom, irq}, 16'h0002);
      wb(1'b0, 4'h2, 32'h00000000, r);
      chk(r[15:0], 16'h0000);
      for (int i = 0; i < 3; i++) wr(1'b0, 5'(i), {8'h00, ctl_v[i]});
      for (int i = 0; i < 3; i++) rc(1'b0, 5'(i), {8'h00, ctl_v[i]});
      wr(1'b1, t16_pkg::A_CNTL, 16'h1234);
      rc(1'b1, t16_pkg::A_CNTL, 16'h1234);
      rc(1'b1, t16_pkg::A_CNTL, 16'h1234);
      wr(1'b1, t16_pkg::A_CMPL, 16'h4321);
      wr(1'b0, t16_pkg::A_CMPL + 5'h01, 16'h009A);
      rc(1'b1, t16_pkg::A_CMPL, 16'h4321);
      wr(1'b0, t16_pkg::A_CNTL, 16'h00BC);
      rc(1'b1, t16_pkg::A_CNTL, 16'h9ABC);
      wr(1'b0, t16_pkg::A_CNTH, 16'h0000);
      rc(1'b0, t16_pkg::A_CNTL, 16'h00BC);
      rc(1'b0, t16_pkg::A_CAPH, 16'h009A);
      rc(1'b0, t16_pkg::A_CMPL + 5'h01, 16'h0043);
      wr(1'b1, t16_pkg::A_CNTL, 16'hFFFF);
      chk({14'h0000, maxv, bottom}, 16'h0002);
      wr(1'b1, t16_pkg::A_CNTL, 16'h0000);
      chk({14'h0000, maxv, bottom}, 16'h0001);
      wr(1'b0, t16_pkg::A_CTLB, 16'h0040);
      wr(1'b1, t16_pkg::A_CNTL, 16'h2222);
      wr(1'b0, t16_pkg::A_FLAG, 16'h001F);
      cap_pin <= 1'b1;
      repeat (10) @(posedge clk_i);
      rc(1'b1, t16_pkg::A_CAPL, 16'h2222);
      fc(16'h0010, 16'h0010);
      wr(1'b0, t16_pkg::A_CTLC, 16'h0001);
      wr(1'b1, t16_pkg::A_CNTL, 16'h3333);
      cmp_pin <= 1'b1;
      repeat (10) @(posedge clk_i);
      rc(1'b1, t16_pkg::A_CAPL, 16'h3333);
      wr(1'b1, t16_pkg::A_CAPL, 16'h5555);
      rc(1'b1, t16_pkg::A_CAPL, 16'h3333);
      wr(1'b0, t16_pkg::A_CTLC, 16'h0000);
      wr(1'b0, t16_pkg::A_CTLB, 16'h0018);
      wr(1'b1, t16_pkg::A_CAPL, 16'h0055);
      rc(1'b1, t16_pkg::A_CAPL, 16'h0055);
      wr(1'b1, t16_pkg::A_CNTL, 16'h0000);
      wr(1'b0, t16_pkg::A_FLAG, 16'h001F);
      wr(1'b0, t16_pkg::A_CTLB, 16'h0019);
      repeat (300) @(posedge clk_i);
      op(1'b0, 1'b1, t16_pkg::A_CNTL, 16'h0000, q);
      chk({15'h0000, q <= 16'h0055}, 16'h0001);
      fc(16'h0001, 16'h0001);
      wr(1'b0, t16_pkg::A_CTLB, 16'h0000);
      wr(1'b1, t16_pkg::A_CMPL + t16_pkg::A_STEP, 16'h0040);
      wr(1'b1, t16_pkg::A_CNTL, 16'h0000);
      wr(1'b0, t16_pkg::A_FLAG, 16'h001F);
      w0 = wave;
      wr(1'b0, t16_pkg::A_CTLB, {13'h0000, t16_pkg::CS_SYS});
      repeat (200) @(posedge clk_i);
      wr(1'b0, t16_pkg::A_CTLB, 16'h0000);
      fc(16'h0006, 16'h0004);
      chk({13'h0000, wave}, {13'h0000, w0 ^ 3'h6});
      chk({15'h0000, irq}, 16'h0000);
      wr(1'b0, t16_pkg::A_MASK, 16'h0004);
      repeat (4) @(posedge clk_i);
      chk({15'h0000, irq}, 16'h0001);
      wr(1'b0, t16_pkg::A_FLAG, 16'h0004);
      repeat (4) @(posedge clk_i);
      chk({15'h0000, irq}, 16'h0000);
      fc(16'h0004, 16'h0000);
      wr(1'b1, t16_pkg::A_CNTL, 16'h0000);
      wr(1'b0, t16_pkg::A_CTLB, {13'h0000, t16_pkg::CS_RISE});
      for (int i = 0; i < 3; i++) begin
         ext_pin <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext_pin <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      wr(1'b0, t16_pkg::A_CTLB, 16'h0000);
      rc(1'b1, t16_pkg::A_CNTL, 16'h0003);
      complete_run();
   end
endmodule // tb
